// *** dbio_host.sv ***
// host bus model issuing byte-wide i/o cycles toward the card
`timescale 1ns/10ps
module dbio_host
   import dbio_pkg::*;
(
   input  wire logic       clk,
   output logic            host_rd,
   output logic            host_wr,
   output logic [9:0]      host_addr,
   output logic [7:0]      host_wdata,
   input  wire logic [7:0] host_rdata,
   input  wire logic       host_rdata_oe
);
   // ****************************************
   // bus cycles
   // ****************************************
   // idle bus: no command, address parked outside any block
   initial
   begin
      host_rd    = 1'b0;
      host_wr    = 1'b0;
      host_addr  = 10'h000;
      host_wdata = 8'h00;
   end

   // one write, held four clocks so the synchronisers see it; one byte per cycle
   task automatic wr_byte(input logic [9:0] a, input logic [7:0] d);
      @(negedge clk);
      host_addr  = a;
      host_wdata = d;
      host_wr    = 1'b1;
      repeat (4) @(negedge clk);
      host_wr    = 1'b0;
      host_wdata = ~d; // a released bus must not keep showing the last byte
      repeat (6) @(negedge clk);
   endtask

   // one read; returns {drive enable, data} taken while the command still stands
   task automatic rd_byte(input logic [9:0] a, output logic [8:0] q);
      @(negedge clk);
      host_addr = a;
      host_rd   = 1'b1;
      repeat (7) @(negedge clk);
      q       = {host_rdata_oe, host_rdata};
      host_rd = 1'b0;
      repeat (6) @(negedge clk);
   endtask
endmodule

// *** dbio_pkg.sv ***
// package for the acquisition card i/o register decode
package dbio_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [3:0] DBIO_OFF_CNT0   = 4'h0;
   localparam logic [3:0] DBIO_OFF_CNT1   = 4'h1;
   localparam logic [3:0] DBIO_OFF_CNT2   = 4'h2;
   localparam logic [3:0] DBIO_OFF_CTRLW  = 4'h3;
   localparam logic [3:0] DBIO_OFF_LOW0   = 4'h4;
   localparam logic [3:0] DBIO_OFF_HIGH0  = 4'h5;
   localparam logic [3:0] DBIO_OFF_LOW1   = 4'h6;
   localparam logic [3:0] DBIO_OFF_HIGH1  = 4'h7;
   localparam logic [3:0] DBIO_OFF_STAT   = 4'h8;
   localparam logic [3:0] DBIO_OFF_GAIN   = 4'h9;
   localparam logic [3:0] DBIO_OFF_CHAN   = 4'ha;
   localparam logic [3:0] DBIO_OFF_MODE   = 4'hb;
   localparam logic [3:0] DBIO_OFF_TRIG   = 4'hc;
   localparam logic [3:0] DBIO_OFF_DOLO   = 4'hd;
   localparam logic [3:0] DBIO_OFF_DOHI   = 4'he;
   // ****************************************
   // field positions, mode codes and reset values
   // ****************************************
   localparam int         DBIO_READY_BIT  = 4;
   localparam logic [7:0] DBIO_IDLE_BYTE  = 8'hff;
   localparam logic [1:0] DBIO_GAIN_RST   = 2'h0;
   localparam logic [3:0] DBIO_CHAN_RST   = 4'h0;
   localparam logic [2:0] DBIO_MODE_RST   = 3'h0;
   localparam logic [2:0] DBIO_MODE_POLL  = 3'h1;
   localparam logic [2:0] DBIO_MODE_DMA   = 3'h2;
   localparam logic [2:0] DBIO_MODE_INT   = 3'h6;
   localparam logic [5:0] DBIO_BASE_RST   = 6'h22;
   // host bus cycle as seen after the pin synchronisers
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [9:0] addr;
      logic [7:0] data;
   } dbio_bus_t;
   // timer port access toward the timer block
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [1:0] sel;
      logic [7:0] data;
   } dbio_tmr_t;
endpackage

// *** dbio_regs.sv ***
// i/o register decode of the acquisition card
`timescale 1ns/10ps
module dbio_regs
   import dbio_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [5:0]  base_sel,
   input  wire logic        host_rd,
   input  wire logic        host_wr,
   input  wire logic [9:0]  host_addr,
   input  wire logic [7:0]  host_wdata,
   output logic [7:0]       host_rdata,
   output logic             host_rdata_oe,
   input  wire logic [15:0] conv_result,
   input  wire logic        conv_start,
   input  wire logic        conv_done,
   input  wire logic [15:0] digital_inputs,
   input  wire logic [7:0]  tmr_rdata,
   output dbio_tmr_t        tmr_req,
   output logic [11:0]      dac_first_code,
   output logic [11:0]      dac_second_code,
   output logic [1:0]       gain_code,
   output logic [3:0]       chan_code,
   output logic [2:0]       mode_code,
   output logic             soft_trigger,
   output logic             irq_req,
   output logic [15:0]      digital_outputs
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   // every host pin and the input pins cross two flops before use
   dbio_bus_t   bus_s1_q;
   dbio_bus_t   bus_q;
   logic [15:0] din_s1_q;
   logic [15:0] din_q;
   logic [5:0]  base_s1_q;
   logic [5:0]  base_q;
   logic        rd_prev_q;
   logic        wr_prev_q;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         bus_s1_q  <= '0;
         bus_q     <= '0;
         din_s1_q  <= '0;
         din_q     <= '0;
         base_s1_q <= DBIO_BASE_RST;
         base_q    <= DBIO_BASE_RST;
         rd_prev_q <= 1'b0;
         wr_prev_q <= 1'b0;
      end
      else
      begin
         bus_s1_q  <= '{rd: host_rd, wr: host_wr, addr: host_addr, data: host_wdata};
         bus_q     <= bus_s1_q;
         din_s1_q  <= digital_inputs;
         din_q     <= din_s1_q;
         base_s1_q <= base_sel;
         base_q    <= base_s1_q;
         rd_prev_q <= bus_q.rd;
         wr_prev_q <= bus_q.wr;
      end
   end

   // ****************************************
   // address decode
   // ****************************************
   // one strobe per host cycle: act on the rising edge of the
   // synchronised command, so a long bus cycle is one access
   function automatic logic hit(input logic [3:0] off, input logic [3:0] want);
      hit = (off == want);
   endfunction

   wire       in_block = (bus_q.addr[9:4] == base_q);
   wire [3:0] off      = bus_q.addr[3:0];
   wire       wr_stb   = bus_q.wr & ~wr_prev_q & in_block;
   wire       rd_stb   = bus_q.rd & ~rd_prev_q & in_block;
   wire       rd_lvl   = bus_q.rd & in_block;
   wire       tmr_hit  = (off <= DBIO_OFF_CNT2);
   wire       tmr_ctl  = hit(off, DBIO_OFF_CTRLW) & wr_stb;
   wire       clr_stb  = wr_stb & hit(off, DBIO_OFF_STAT);

   // ****************************************
   // stored registers
   // ****************************************
   logic [7:0]  stage0_q;
   logic [7:0]  stage1_q;
   logic [11:0] dac0_q;
   logic [11:0] dac1_q;
   logic [1:0]  gain_q;
   logic [3:0]  chan_q;
   logic [2:0]  mode_q;
   logic [15:0] dout_q;
   logic        trig_q;
   logic        ready_n_q;
   logic        irq_stat_q;
   logic [7:0]  rdata_q;
   logic        rdoe_q;
   dbio_tmr_t   tmr_q;

   // low bytes only stage; the 12-bit latch takes the staged byte
   // with the high nibble so the converter never sees a half code
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         stage0_q <= '0;
         stage1_q <= '0;
         dac0_q   <= '0;
         dac1_q   <= '0;
         gain_q   <= DBIO_GAIN_RST;
         chan_q   <= DBIO_CHAN_RST;
         mode_q   <= DBIO_MODE_RST;
         dout_q   <= '0;
      end
      else if (wr_stb)
      begin
         case (off)
            DBIO_OFF_LOW0:  stage0_q <= bus_q.data;
            DBIO_OFF_HIGH0: dac0_q <= {bus_q.data[3:0], stage0_q};
            DBIO_OFF_LOW1:  stage1_q <= bus_q.data;
            DBIO_OFF_HIGH1: dac1_q <= {bus_q.data[3:0], stage1_q};
            DBIO_OFF_GAIN:  gain_q <= bus_q.data[1:0];
            DBIO_OFF_CHAN:  chan_q <= bus_q.data[3:0];
            DBIO_OFF_MODE:  mode_q <= bus_q.data[2:0];
            DBIO_OFF_DOLO:  dout_q[7:0] <= bus_q.data;
            DBIO_OFF_DOHI:  dout_q[15:8] <= bus_q.data;
            default:        dout_q <= dout_q;
         endcase
      end
   end

   // ****************************************
   // conversion status and interrupt
   // ****************************************
   // done wins over start if both arrive together, and a done in
   // the clear cycle keeps the status bit set in interrupt mode so no event is lost
   wire int_mode = (mode_q == DBIO_MODE_INT);
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         trig_q     <= 1'b0;
         ready_n_q  <= 1'b1;
         irq_stat_q <= 1'b0;
      end
      else
      begin
         trig_q <= wr_stb & hit(off, DBIO_OFF_TRIG);
         if (conv_done)
            ready_n_q <= 1'b0;
         else if (conv_start)
            ready_n_q <= 1'b1;
         if (conv_done & int_mode)
            irq_stat_q <= 1'b1;
         else if (clr_stb)
            irq_stat_q <= 1'b0;
      end
   end

   // ****************************************
   // read mux and timer port
   // ****************************************
   // reserved offsets return all ones and touch nothing
   logic [7:0] rd_mux;
   always_comb
   begin
      case (off)
         DBIO_OFF_LOW0:  rd_mux = conv_result[7:0];
         DBIO_OFF_HIGH0: rd_mux = conv_result[15:8];
         DBIO_OFF_LOW1:  rd_mux = din_q[7:0];
         DBIO_OFF_HIGH1: rd_mux = din_q[15:8];
         DBIO_OFF_STAT:  rd_mux = {3'h7, ready_n_q, 4'hf};
         DBIO_OFF_CNT0,
         DBIO_OFF_CNT1,
         DBIO_OFF_CNT2:  rd_mux = tmr_rdata;
         default:        rd_mux = DBIO_IDLE_BYTE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rdata_q <= DBIO_IDLE_BYTE;
         rdoe_q  <= 1'b0;
         tmr_q   <= '0;
      end
      else
      begin
         rdata_q   <= rd_mux;
         rdoe_q    <= rd_lvl;
         tmr_q.rd  <= rd_stb & tmr_hit;
         tmr_q.wr  <= wr_stb & (tmr_hit | tmr_ctl);
         tmr_q.sel <= off[1:0];
         tmr_q.data <= bus_q.data;
      end
   end

   assign host_rdata      = rdata_q;
   assign host_rdata_oe   = rdoe_q;
   assign tmr_req         = tmr_q;
   assign dac_first_code  = dac0_q;
   assign dac_second_code = dac1_q;
   assign gain_code       = gain_q;
   assign chan_code       = chan_q;
   assign mode_code       = mode_q;
   assign soft_trigger    = trig_q;
   assign irq_req         = irq_stat_q;
   assign digital_outputs = dout_q;

   // ****************************************
   // checks
   // ****************************************
   a_trig_pulse: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_TRIG) |=> soft_trigger ##1 !soft_trigger)
      else $error("trigger pulse missing or too long");
   a_ready_done: assert property (@(posedge clk) disable iff (reset)
      conv_done |=> !ready_n_q)
      else $error("ready flag not cleared on done");
   a_ready_start: assert property (@(posedge clk) disable iff (reset)
      (conv_start && !conv_done) |=> ready_n_q)
      else $error("ready flag not set on start");
   a_irq_clear: assert property (@(posedge clk) disable iff (reset)
      (clr_stb && !conv_done) |=> !irq_req)
      else $error("status bit not cleared");
   a_irq_set: assert property (@(posedge clk) disable iff (reset)
      (conv_done && int_mode) |=> irq_req)
      else $error("status bit not set in interrupt mode");
   a_dac_hold: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_LOW0) |=> $stable(dac_first_code))
      else $error("latch moved on low byte write");
   a_dac_load: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_HIGH1)
      |=> dac_second_code == {$past(bus_q.data[3:0]), stage1_q})
      else $error("second latch wrong after high write");
   a_gain_load: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_GAIN) |=> gain_code == $past(bus_q.data[1:0]))
      else $error("gain not stored");
   a_outside: assert property (@(posedge clk) disable iff (reset)
      (bus_q.wr && !in_block) |=> $stable(digital_outputs) && !soft_trigger)
      else $error("access outside block acted");
   a_status_rd: assert property (@(posedge clk) disable iff (reset)
      (rd_lvl && off == DBIO_OFF_STAT) |=> host_rdata[DBIO_READY_BIT] == $past(ready_n_q))
      else $error("status read wrong");

   // ****************************************
   // latch and field checks
   // ****************************************
   // each stored field must take exactly the documented bits of the strobed byte
   a_dac0_load: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_HIGH0) |=> dac_first_code == {$past(bus_q.data[3:0]), stage0_q})
      else $error("first latch wrong after high write");
   a_high_nibble: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_HIGH0) |=> dac_first_code[11:8] == $past(bus_q.data[3:0]))
      else $error("high nibble wrong in first latch");
   a_dac1_hold: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_LOW1) |=> $stable(dac_second_code))
      else $error("second latch moved on low byte write");
   a_stage0_load: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_LOW0) |=> stage0_q == $past(bus_q.data))
      else $error("first staging byte not taken");
   a_stage1_load: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_LOW1) |=> stage1_q == $past(bus_q.data))
      else $error("second staging byte not taken");
   a_dac0_keep: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_HIGH1) |=> $stable(dac_first_code))
      else $error("first latch moved on second channel write");
   a_chan_load: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_CHAN) |=> chan_code == $past(bus_q.data[3:0]))
      else $error("channel not stored");
   a_mode_load: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_MODE) |=> mode_code == $past(bus_q.data[2:0]))
      else $error("mode not stored");
   a_dout_low: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_DOLO) |=> digital_outputs[7:0] == $past(bus_q.data))
      else $error("output low byte not stored");
   a_dout_high: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off == DBIO_OFF_DOHI) |=> digital_outputs[15:8] == $past(bus_q.data))
      else $error("output high byte not stored");
   a_gain_keep: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off != DBIO_OFF_GAIN) |=> $stable(gain_code))
      else $error("gain moved on other write");

   // timer routing and trigger: one pulse per strobe, never on its own
   a_tmr_wr: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off <= DBIO_OFF_CTRLW) |=> tmr_req.wr && tmr_req.sel == $past(off[1:0]))
      else $error("timer write not routed");
   a_tmr_data: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && off <= DBIO_OFF_CTRLW) |=> tmr_req.data == $past(bus_q.data))
      else $error("timer write byte wrong");
   a_tmr_rd: assert property (@(posedge clk) disable iff (reset)
      (rd_stb && off <= DBIO_OFF_CNT2) |=> tmr_req.rd)
      else $error("timer read not routed");
   a_tmr_ctl_rd: assert property (@(posedge clk) disable iff (reset)
      (rd_stb && off == DBIO_OFF_CTRLW) |=> !tmr_req.rd)
      else $error("control word port read reached timer");
   a_tmr_quiet: assert property (@(posedge clk) disable iff (reset)
      (!wr_stb && !rd_stb) |=> !tmr_req.rd && !tmr_req.wr)
      else $error("timer access without a host strobe");
   a_timer_rdata: assert property (@(posedge clk) disable iff (reset)
      (rd_lvl && off <= DBIO_OFF_CNT2) |=> host_rdata == $past(tmr_rdata))
      else $error("timer read byte wrong");
   a_trig_only: assert property (@(posedge clk) disable iff (reset)
      !(wr_stb && off == DBIO_OFF_TRIG) |=> !soft_trigger)
      else $error("trigger without a trigger write");

   // status, interrupt and read path
   a_irq_hold: assert property (@(posedge clk) disable iff (reset)
      (irq_req && !clr_stb) |=> irq_req)
      else $error("status bit dropped without a clear");
   a_irq_quiet: assert property (@(posedge clk) disable iff (reset)
      (!irq_req && !(conv_done && int_mode)) |=> !irq_req)
      else $error("status bit set without an event");
   a_irq_poll: assert property (@(posedge clk) disable iff (reset)
      (conv_done && !int_mode && !irq_req) |=> !irq_req)
      else $error("status bit set outside interrupt mode");
   a_ready_hold: assert property (@(posedge clk) disable iff (reset)
      (!conv_done && !conv_start) |=> $stable(ready_n_q))
      else $error("ready flag moved without an event");
   a_rd_oe: assert property (@(posedge clk) disable iff (reset)
      rd_lvl |=> host_rdata_oe)
      else $error("data bus not driven during read");
   a_rd_quiet: assert property (@(posedge clk) disable iff (reset)
      !rd_lvl |=> !host_rdata_oe)
      else $error("data bus driven outside a read");
   a_outside_rd: assert property (@(posedge clk) disable iff (reset)
      (bus_q.rd && !in_block) |=> !host_rdata_oe)
      else $error("read outside block answered");
   a_result_lo: assert property (@(posedge clk) disable iff (reset)
      (rd_lvl && off == DBIO_OFF_LOW0) |=> host_rdata == $past(conv_result[7:0]))
      else $error("result low byte wrong");
   a_result_hi: assert property (@(posedge clk) disable iff (reset)
      (rd_lvl && off == DBIO_OFF_HIGH0) |=> host_rdata == $past(conv_result[15:8]))
      else $error("result high byte wrong");
   a_din_lo: assert property (@(posedge clk) disable iff (reset)
      (rd_lvl && off == DBIO_OFF_LOW1) |=> host_rdata == $past(din_q[7:0]))
      else $error("input low byte wrong");
   a_din_hi: assert property (@(posedge clk) disable iff (reset)
      (rd_lvl && off == DBIO_OFF_HIGH1) |=> host_rdata == $past(din_q[15:8]))
      else $error("input high byte wrong");
   a_reserved_rd: assert property (@(posedge clk) disable iff (reset)
      (rd_lvl && off > DBIO_OFF_STAT) |=> host_rdata == DBIO_IDLE_BYTE)
      else $error("reserved read not idle value");
   a_rd_no_side: assert property (@(posedge clk) disable iff (reset)
      (rd_stb && off > DBIO_OFF_STAT) |=> $stable(gain_code) && $stable(digital_outputs))
      else $error("reserved read changed state");
endmodule

// *** dbio_regs_tb.sv ***
// self-checking bench for the card's i/o register decode
`timescale 1ns/10ps
module dbio_regs_tb;
   import dbio_pkg::*;
   // ****************************************
   // signals and helpers
   // ****************************************
   logic        clk, reset, host_rd, host_wr, host_rdata_oe, conv_start, conv_done;
   logic        soft_trigger, irq_req;
   logic [9:0]  host_addr;
   logic [7:0]  host_wdata, host_rdata, tmr_rdata;
   logic [15:0] conv_result, digital_inputs, digital_outputs;
   logic [11:0] dac_first_code, dac_second_code;
   logic [1:0]  gain_code;
   logic [3:0]  chan_code;
   logic [2:0]  mode_code;
   logic [5:0]  base_sel;
   logic [8:0]  q;
   dbio_tmr_t   tmr_req, tmr_seen;
   int          miscompares, samples_checked, trig_cnt;
   logic [15:0] codes [4] = '{16'h7fff, 16'h0000, 16'hffff, 16'h8000};

   dbio_regs dut (.clk(clk), .reset(reset), .base_sel(base_sel), .host_rd(host_rd),
      .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe), .conv_result(conv_result),
      .conv_start(conv_start), .conv_done(conv_done), .digital_inputs(digital_inputs),
      .tmr_rdata(tmr_rdata), .tmr_req(tmr_req), .dac_first_code(dac_first_code),
      .dac_second_code(dac_second_code), .gain_code(gain_code), .chan_code(chan_code),
      .mode_code(mode_code), .soft_trigger(soft_trigger), .irq_req(irq_req),
      .digital_outputs(digital_outputs));

   dbio_host u_host (.clk(clk), .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // count trigger pulses and keep the last timer access, since both last one cycle
   always @(posedge clk)
   begin
      if (soft_trigger === 1'b1)
         trig_cnt <= trig_cnt + 1;
      if (tmr_req.rd === 1'b1 || tmr_req.wr === 1'b1)
         tmr_seen <= tmr_req;
   end

   function automatic logic [9:0] at_off(input logic [3:0] off);
      return {DBIO_BASE_RST, off};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conv_pulse(input bit done);
      @(negedge clk);
      if (done)
         conv_done = 1'b1;
      else
         conv_start = 1'b1;
      @(negedge clk);
      conv_done  = 1'b0;
      conv_start = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   task automatic complete_run;
      if (miscompares == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // hang guard, far beyond the roughly 500 cycles the tests need
   initial
   begin
      #200000;
      miscompares++;
      complete_run();
   end

   // ****************************************
   // tests
   // ****************************************
   initial
   begin
      reset = 1'b1;
      base_sel = DBIO_BASE_RST;
      conv_start = 1'b0;
      conv_done = 1'b0;
      conv_result = 16'h0000;
      digital_inputs = 16'h5aa5;
      tmr_rdata = 8'h77;
      trig_cnt = 0;
      repeat (6) @(negedge clk);
      reset = 1'b0;
      u_host.rd_byte(at_off(DBIO_OFF_STAT), q);
      check(16'(q[DBIO_READY_BIT]), 16'h1);
      u_host.rd_byte(at_off(DBIO_OFF_GAIN), q);
      check(16'(q), 16'h1ff);
      u_host.rd_byte(at_off(DBIO_OFF_CTRLW), q);
      check(16'(q), 16'h1ff);
      for (int g = 0; g < 4; g++)
      begin
         u_host.wr_byte(at_off(DBIO_OFF_GAIN), 8'hfc | 8'(g));
         check(16'(gain_code), 16'(g));
      end
      u_host.wr_byte({DBIO_BASE_RST + 6'h1, DBIO_OFF_GAIN}, 8'h00);
      check(16'(gain_code), 16'h3);
      u_host.rd_byte({DBIO_BASE_RST ^ 6'h1, DBIO_OFF_STAT}, q);
      check(16'(q[8]), 16'h0);
      u_host.wr_byte(at_off(DBIO_OFF_CHAN), 8'hf5);
      check(16'(chan_code), 16'h5);
      u_host.wr_byte(at_off(DBIO_OFF_MODE), 8'hf9);
      check(16'(mode_code), 16'(DBIO_MODE_POLL));
      // host waits out the gain settling before it triggers
      repeat (8) @(negedge clk);
      trig_cnt = 0;
      u_host.wr_byte(at_off(DBIO_OFF_TRIG), 8'h5a);
      check(16'(trig_cnt), 16'h1);
      conv_pulse(1'b1);
      u_host.rd_byte(at_off(DBIO_OFF_STAT), q);
      check(16'(q[DBIO_READY_BIT]), 16'h0);
      check(16'(irq_req), 16'h0);
      conv_pulse(1'b0);
      u_host.rd_byte(at_off(DBIO_OFF_STAT), q);
      check(16'(q[DBIO_READY_BIT]), 16'h1);
      u_host.wr_byte(at_off(DBIO_OFF_MODE), 8'(DBIO_MODE_INT));
      conv_pulse(1'b1);
      conv_pulse(1'b1);
      check(16'(irq_req), 16'h1);
      u_host.wr_byte(at_off(DBIO_OFF_STAT), 8'ha5);
      check(16'(irq_req), 16'h0);
      conv_pulse(1'b1);
      check(16'(irq_req), 16'h1);
      // low byte always goes first so each latched code is coherent
      u_host.wr_byte(at_off(DBIO_OFF_LOW0), 8'h34);
      check(16'(dac_first_code), 16'h0);
      u_host.wr_byte(at_off(DBIO_OFF_HIGH0), 8'ha7);
      check(16'(dac_first_code), 16'h734);
      u_host.wr_byte(at_off(DBIO_OFF_LOW1), 8'hcd);
      check(16'(dac_second_code), 16'h0);
      u_host.wr_byte(at_off(DBIO_OFF_HIGH1), 8'hfe);
      check(16'(dac_second_code), 16'hecd);
      check(16'(dac_first_code), 16'h734);
      for (int i = 0; i < 4; i++)
      begin
         conv_result = codes[i];
         u_host.rd_byte(at_off(DBIO_OFF_LOW0), q);
         check(16'(q), {8'h01, codes[i][7:0]});
         u_host.rd_byte(at_off(DBIO_OFF_HIGH0), q);
         check(16'(q), {8'h01, codes[i][15:8]});
      end
      u_host.rd_byte(at_off(DBIO_OFF_LOW1), q);
      check(16'(q), 16'h1a5);
      u_host.rd_byte(at_off(DBIO_OFF_HIGH1), q);
      check(16'(q), 16'h15a);
      u_host.wr_byte(at_off(DBIO_OFF_CNT1), 8'h3c);
      check(16'(tmr_seen), {4'h0, 2'b01, 2'h1, 8'h3c});
      u_host.wr_byte(at_off(DBIO_OFF_CTRLW), 8'hb6);
      check(16'(tmr_seen), {4'h0, 2'b01, 2'h3, 8'hb6});
      u_host.rd_byte(at_off(DBIO_OFF_CNT2), q);
      check(16'(q), 16'h177);
      check(16'(tmr_seen[11:8]), 16'ha);
      u_host.wr_byte(at_off(DBIO_OFF_DOLO), 8'h3c);
      u_host.wr_byte(at_off(DBIO_OFF_DOHI), 8'hc3);
      check(digital_outputs, 16'hc33c);
      // move the block to another base; the old base must go dead
      base_sel = 6'h30;
      repeat (4) @(negedge clk);
      u_host.wr_byte({6'h30, DBIO_OFF_GAIN}, 8'h01);
      check(16'(gain_code), 16'h1);
      u_host.wr_byte(at_off(DBIO_OFF_GAIN), 8'h02);
      check(16'(gain_code), 16'h1);
      complete_run();
   end
endmodule
